// [mcr_pkg.sv]
// Package for the miscellaneous configuration and self-test register bank.
package mcr_pkg;

  // Register offsets.
  localparam logic [7:0] MCR_OFS_IDENTITY = 8'h18;
  localparam logic [7:0] MCR_OFS_STARTUP = 8'h1a;
  localparam logic [7:0] MCR_OFS_FREE = 8'h1b;
  localparam logic [7:0] MCR_OFS_POWER = 8'h1c;
  localparam logic [7:0] MCR_OFS_XDRIVE = 8'h20;
  localparam logic [7:0] MCR_OFS_YDRIVE = 8'h21;
  localparam logic [7:0] MCR_OFS_ZDRIVE = 8'h22;

  // Identity value; arbitrary neutral value.
  localparam logic [7:0] MCR_IDENTITY_VALUE = 8'h5a;

  // Reset values.
  localparam logic [7:0] MCR_RST_BYTE = 8'h00;
  localparam logic [2:0] MCR_RST_LEVEL = 3'h0;

  // Field positions.
  localparam int MCR_POS_HSE = 7;
  localparam int MCR_POS_POS_DEFLECT = 2;
  localparam int MCR_POS_NEG_DEFLECT = 3;

  // Y drive read-back values.
  localparam logic [7:0] MCR_YREAD_AWAKE = 8'h80;
  localparam logic [7:0] MCR_YREAD_IDLE = 8'h00;

  // Power level codes.
  typedef enum logic [2:0] {
    MCR_LVL_LOW = 3'b000,
    MCR_LVL_ULTRA = 3'b011,
    MCR_LVL_PRECISION = 3'b100
  } mcr_level_t;

  // Operating states.
  typedef enum logic [2:0] {
    MCR_ST_SLEEP = 3'b000,
    MCR_ST_STANDBY = 3'b001,
    MCR_ST_WATCH = 3'b010,
    MCR_ST_CONT_ACTIVE = 3'b101,
    MCR_ST_WATCH_ACTIVE = 3'b110,
    MCR_ST_TRIGGERED = 3'b111
  } mcr_state_t;

  // Per-axis self-test drive.
  typedef struct packed {
    logic negative_deflect;
    logic positive_deflect;
  } mcr_deflect_t;

  // Power setting outputs.
  typedef struct packed {
    logic [2:0] watch_power_level;
    logic [2:0] active_power_level;
  } mcr_power_t;

endpackage : mcr_pkg

// [mcr_regs.sv]
// Configuration, power level and self-test drive register bank.
//
// Function
// - Identity byte read-only, writes ignored.
// - Free byte stores value, no side effects.
// - Bits 2:0 select active power level.
// - Bits 6:4 select watch power level.
// - High-speed serial enable reads zero.
// - X drive bits 2,3 deflect X.
// - X drive write initialises internal bits.
// - Y drive bits 2,3 deflect Y.
// - Y read-back follows operating state.
// - Z drive bits 2,3 deflect Z.
`timescale 1ns/1ps
`default_nettype none
module mcr_regs
  import mcr_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register access port from the serial interface logic.
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Operating state from the mode controller.
  input wire logic [2:0] i_operating_state_field,
  // Controls to the analog front end.
  output mcr_power_t o_power,
  output logic o_high_speed_serial_enable,
  output mcr_deflect_t o_x_drive,
  output mcr_deflect_t o_y_drive,
  output mcr_deflect_t o_z_drive,
  output logic o_init_bits_pulse,
  output logic [7:0] o_startup_config
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] startup_reg;
  logic [7:0] free_reg;
  mcr_power_t power_reg;
  logic hse_reg;
  mcr_deflect_t x_reg;
  mcr_deflect_t y_reg;
  mcr_deflect_t z_reg;
  logic init_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] rdata_next;

  function automatic logic is_awake(input logic [2:0] st);
    is_awake = (st == MCR_ST_WATCH) || (st == MCR_ST_CONT_ACTIVE) ||
               (st == MCR_ST_WATCH_ACTIVE) || (st == MCR_ST_TRIGGERED);
  endfunction : is_awake

  function automatic mcr_deflect_t deflect_of(input logic [7:0] d);
    deflect_of.positive_deflect = d[MCR_POS_POS_DEFLECT];
    deflect_of.negative_deflect = d[MCR_POS_NEG_DEFLECT];
  endfunction : deflect_of

  ////////////////////////////////////////////////////////////////////////////
  // Plain storage registers.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      startup_reg <= MCR_RST_BYTE;
      free_reg <= MCR_RST_BYTE;
    end
    else if (i_wr)
    begin
      if (i_addr == MCR_OFS_STARTUP)
      begin
        startup_reg <= i_wdata;
      end
      else if (i_addr == MCR_OFS_FREE)
      begin
        free_reg <= i_wdata;
      end
    end
  end

  // Power setting register.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      power_reg <= {MCR_RST_LEVEL, MCR_RST_LEVEL};
      hse_reg <= 1'b0;
    end
    else if (i_wr && i_addr == MCR_OFS_POWER)
    begin
      power_reg.active_power_level <= i_wdata[2:0];
      power_reg.watch_power_level <= i_wdata[6:4];
      hse_reg <= i_wdata[MCR_POS_HSE];
    end
  end

  // Self-test drive registers.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
    end
    else if (i_wr)
    begin
      if (i_addr == MCR_OFS_XDRIVE)
      begin
        x_reg <= deflect_of(i_wdata);
      end
      else if (i_addr == MCR_OFS_YDRIVE)
      begin
        y_reg <= deflect_of(i_wdata);
      end
      else if (i_addr == MCR_OFS_ZDRIVE)
      begin
        z_reg <= deflect_of(i_wdata);
      end
    end
  end

  // One-cycle pulse that initialises internal bits on an X drive write.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      init_reg <= 1'b0;
    end
    else
    begin
      init_reg <= i_wr && (i_addr == MCR_OFS_XDRIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped and write-only locations read zero.
  always_comb
  begin
    rdata_next = MCR_RST_BYTE;
    if (i_addr == MCR_OFS_IDENTITY)
    begin
      rdata_next = MCR_IDENTITY_VALUE;
    end
    else if (i_addr == MCR_OFS_STARTUP)
    begin
      rdata_next = startup_reg;
    end
    else if (i_addr == MCR_OFS_FREE)
    begin
      rdata_next = free_reg;
    end
    else if (i_addr == MCR_OFS_POWER)
    begin
      rdata_next = {1'b0, power_reg.watch_power_level, 1'b0,
                    power_reg.active_power_level};
    end
    else if (i_addr == MCR_OFS_YDRIVE)
    begin
      rdata_next = is_awake(i_operating_state_field) ? MCR_YREAD_AWAKE
                                                      : MCR_YREAD_IDLE;
    end
    else if (i_addr == MCR_OFS_ZDRIVE)
    begin
      rdata_next = {4'h0, z_reg.negative_deflect, z_reg.positive_deflect,
                    2'h0};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_reg <= MCR_RST_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= i_rd;
      if (i_rd)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_power = power_reg;
  assign o_high_speed_serial_enable = hse_reg;
  assign o_x_drive = x_reg;
  assign o_y_drive = y_reg;
  assign o_z_drive = z_reg;
  assign o_init_bits_pulse = init_reg;
  assign o_startup_config = startup_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_identity_read;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rd && i_addr == MCR_OFS_IDENTITY |=> o_rvalid &&
      o_rdata == MCR_IDENTITY_VALUE;
  endproperty
  a_identity_read: assert property (p_identity_read)
    else $error("Identity byte read wrong.");

  property p_free_store;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_FREE ##1 i_rd && !i_wr && i_addr == MCR_OFS_FREE
      |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_free_store: assert property (p_free_store)
    else $error("Free byte did not keep written value.");

  property p_active_level;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_POWER |=>
      o_power.active_power_level == $past(i_wdata[2:0]);
  endproperty
  a_active_level: assert property (p_active_level)
    else $error("Active power level not updated.");

  property p_watch_level;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_POWER |=>
      o_power.watch_power_level == $past(i_wdata[6:4]);
  endproperty
  a_watch_level: assert property (p_watch_level)
    else $error("Watch power level not updated.");

  property p_hse_reads_zero;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rd && i_addr == MCR_OFS_POWER |=> !o_rdata[MCR_POS_HSE];
  endproperty
  a_hse_reads_zero: assert property (p_hse_reads_zero)
    else $error("High-speed enable read back non-zero.");

  property p_x_drive;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_XDRIVE |=>
      o_x_drive == $past(deflect_of(i_wdata)) && o_init_bits_pulse;
  endproperty
  a_x_drive: assert property (p_x_drive)
    else $error("X drive write not applied.");

  property p_y_drive;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_YDRIVE |=>
      o_y_drive == $past(deflect_of(i_wdata));
  endproperty
  a_y_drive: assert property (p_y_drive)
    else $error("Y drive write not applied.");

  property p_y_readback;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rd && i_addr == MCR_OFS_YDRIVE |=> o_rdata ==
      (is_awake($past(i_operating_state_field)) ? 8'h80 : 8'h00);
  endproperty
  a_y_readback: assert property (p_y_readback)
    else $error("Y drive read-back does not follow state.");

  property p_z_drive;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == MCR_OFS_ZDRIVE |=>
      o_z_drive == $past(deflect_of(i_wdata));
  endproperty
  a_z_drive: assert property (p_z_drive)
    else $error("Z drive write not applied.");

endmodule : mcr_regs
`default_nettype wire

// [mcr_host.sv]
// Host model that drives the register access port.
`timescale 1ns/1ps
`default_nettype none
module mcr_host
  import mcr_pkg::*;
(
  // Clock and read answer.
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // Requests.
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  logic hse_copy = 1'b0;
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  // Released lines show the inverse of their last value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b0, ~a};
    q = {i_rvalid, i_rdata};
  endtask : rd
  // Write then read the same location on the very next edge.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
    output logic [8:0] q);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    {o_wr, o_rd} = 2'b01;
    @(negedge i_clk);
    {o_rd, o_addr, o_wdata} = {1'b0, ~a, ~d};
    q = {i_rvalid, i_rdata};
  endtask : wr_rd
  task automatic init();
    wr(MCR_OFS_STARTUP, 8'h00);
  endtask : init
  task automatic power(input logic [2:0] w, a, input logic h);
    hse_copy = h;
    wr(MCR_OFS_POWER, {hse_copy, w, 1'b0, a});
  endtask : power
  task automatic drive(input logic [7:0] a, input logic [1:0] pn);
    case (a)
      MCR_OFS_XDRIVE: wr(a, {4'h0, pn, 2'b01});
      MCR_OFS_YDRIVE: wr(a, {4'h8, pn, 2'b00});
      default: wr(a, {4'h0, pn, 2'b00});
    endcase
  endtask : drive
endmodule : mcr_host
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  import mcr_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, wr, rd, rvalid, hse, pulse;
  logic [7:0] addr, wdata, rdata, v, scfg;
  logic [8:0] q;
  logic [2:0] st = 3'h0;
  logic [2:0] lv[3] = '{MCR_LVL_LOW, MCR_LVL_ULTRA, MCR_LVL_PRECISION};
  logic [7:0] ofs[6] = '{8'h1a, 8'h1b, 8'h1c, 8'h20, 8'h21, 8'h22};
  mcr_power_t pw;
  mcr_deflect_t xd, yd, zd;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  mcr_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_operating_state_field(st), .o_power(pw),
    .o_high_speed_serial_enable(hse), .o_x_drive(xd), .o_y_drive(yd),
    .o_z_drive(zd), .o_init_bits_pulse(pulse), .o_startup_config(scfg));
  mcr_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  // Y read-back is 0x80 only in the awake states.
  function automatic logic [7:0] y_exp(input logic [2:0] s);
    return (s inside {3'h2, 3'h5, 3'h6, 3'h7}) ? 8'h80 : 8'h00;
  endfunction : y_exp
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    `CHK("rvalid", 1'b1, q[8])
    `CHK("rdata", e, q[7:0])
  endtask : chk_rd
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  initial
  begin
    v = 8'($urandom(48));
    repeat (8) @(negedge i_clk);
    i_reset_n = 1'b1;
    `CHK("reset outs", 22'h0, {pw, hse, xd, yd, zd, pulse, scfg})
    chk_rd(MCR_OFS_IDENTITY, MCR_IDENTITY_VALUE);
    foreach (ofs[i]) chk_rd(ofs[i], 8'h00);
    host.init();
    chk_rd(MCR_OFS_STARTUP, 8'h00);
    host.wr(MCR_OFS_IDENTITY, ~MCR_IDENTITY_VALUE);
    chk_rd(MCR_OFS_IDENTITY, MCR_IDENTITY_VALUE);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      host.wr(MCR_OFS_FREE, v);
      chk_rd(MCR_OFS_FREE, v);
      `CHK("side", 22'h0, {pw, hse, xd, yd, zd, pulse, scfg})
      host.wr_rd(MCR_OFS_FREE, ~v, q);
      `CHK("free b2b", {1'b1, ~v}, q)
    end
    for (int i = 0; i < 9; i++)
    begin
      host.power(lv[i % 3], lv[i / 3], i[0]);
      `CHK("power", {lv[i % 3], lv[i / 3]}, pw)
      `CHK("hse", i[0], hse)
      chk_rd(MCR_OFS_POWER, {1'b0, lv[i % 3], 1'b0, lv[i / 3]});
    end
    for (int i = 0; i < 4; i++)
    begin
      host.drive(MCR_OFS_XDRIVE, 2'(i));
      `CHK("x", 2'(i), xd)
      `CHK("pulse", 1'b1, pulse)
      @(negedge i_clk);
      `CHK("pulse end", 1'b0, pulse)
      host.drive(MCR_OFS_YDRIVE, 2'(i));
      `CHK("y", 2'(i), yd)
      host.drive(MCR_OFS_ZDRIVE, 2'(i));
      `CHK("z", 2'(i), zd)
      chk_rd(MCR_OFS_ZDRIVE, {4'h0, 2'(i), 2'b00});
      chk_rd(MCR_OFS_XDRIVE, 8'h00);
    end
    // Mid-run reset clears every stored setting.
    i_reset_n = 1'b0;
    @(negedge i_clk);
    `CHK("mid reset", 22'h0, {pw, hse, xd, yd, zd, pulse, scfg})
    `CHK("mid rd", 9'h0, {rvalid, rdata})
    i_reset_n = 1'b1;
    host.init();
    chk_rd(MCR_OFS_FREE, 8'h00);
    chk_rd(MCR_OFS_POWER, 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      @(negedge i_clk);
      st = 3'(s);
      chk_rd(MCR_OFS_YDRIVE, y_exp(st));
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
